//--- core/usb_cfg_pkg.sv
package usb_cfg_pkg;
    // Register numbers on the configuration port
    localparam logic [7:0] OFF_ID       = 8'h00;
    localparam logic [7:0] OFF_NODE_CFG = 8'h04;
    localparam logic [7:0] OFF_NODE_ID  = 8'h05;
    localparam logic [7:0] OFF_SYSCLK   = 8'h51;
    localparam logic [7:0] OFF_LINK     = 8'h80;

    // Identification fields
    localparam int ID_CHIP_LO = 24;
    localparam int ID_REV_LO  = 8;
    localparam int ID_VER_LO  = 0;

    // Node configuration fields
    localparam int LOCK_BIT = 31;
    localparam int HDR_BIT  = 0;

    // Link control and status fields
    localparam int ERR_BIT    = 27;
    localparam int ISSUED_BIT = 26;
    localparam int HELD_BIT   = 25;
    localparam int CRT_BIT    = 24;
    localparam int RXRST_BIT  = 23;
    localparam int SYM_HI     = 21;
    localparam int SYM_LO     = 11;
    localparam int TOK_HI     = 10;
    localparam int TOK_LO     = 0;

    // Values after reset and legal range of the clock field
    localparam logic [6:0]  MHZ_RST = 7'h19;
    localparam logic [6:0]  MHZ_MIN = 7'h05;
    localparam logic [6:0]  MHZ_MAX = 7'h64;
    localparam logic [10:0] GAP_RST = 11'h001;
endpackage

//--- core/link_ctl_if.sv
// Strobes from the register bank to the link end, status flags back
interface link_ctl_if;
    logic crt_req;        // Drop credit and send a credit request token
    logic rx_reset_req;   // Restart token framing in the receiver
    logic rx_error;       // Overflow or bad token seen
    logic credit_issued;  // Remote end has been granted credit
    logic credit_held;    // This end may transmit

    modport regs (output crt_req, output rx_reset_req,
                  input rx_error, input credit_issued, input credit_held);
    modport link (input crt_req, input rx_reset_req,
                  output rx_error, output credit_issued, output credit_held);
endinterface

//--- core/link_credit_ctl.sv
// Credit and error state of the serial link end
module link_credit_ctl (
    input  wire logic   clk,
    input  wire logic   nrst,
    link_ctl_if.link    lk,
    input  wire logic   credit_in,
    input  wire logic   credit_issued_in,
    input  wire logic   rx_error_in,
    output logic        credit_request_token,
    output logic        rx_reset
);
    typedef struct packed {
        logic err;     // Sticky receive error
        logic issued;  // Credit given to the remote end
        logic held;    // Credit we own
        logic tok;     // Credit request token pulse
        logic rst;     // Receiver reset pulse
    } st_t;

    st_t s_r;  // Registered state
    st_t s_nxt;  // Next state

    // Hardware sets always win over a clear in the same cycle
    always_comb begin
        s_nxt = s_r;
        s_nxt.tok = lk.crt_req;
        s_nxt.rst = lk.rx_reset_req;
        // Credit drops on a request, regained when the remote end grants it
        if (lk.crt_req) begin
            s_nxt.held = 1'b0;
        end
        if (credit_in) begin
            s_nxt.held = 1'b1;
        end
        // A receiver reset forgets the error and the credit handed out
        if (lk.rx_reset_req) begin
            s_nxt.err    = 1'b0;
            s_nxt.issued = 1'b0;
        end
        if (credit_issued_in) begin
            s_nxt.issued = 1'b1;
        end
        if (rx_error_in) begin
            s_nxt.err = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lk.rx_error      = s_r.err;
    assign lk.credit_issued = s_r.issued;
    assign lk.credit_held   = s_r.held;
    assign credit_request_token = s_r.tok;
    assign rx_reset             = s_r.rst;

    property p_crt_drops;
        @(posedge clk) disable iff (!nrst)
        lk.crt_req && !credit_in |=> !s_r.held && credit_request_token;
    endproperty
    a_crt_drops: assert property (p_crt_drops) else $error("credit kept after request");

    property p_rx_reset;
        @(posedge clk) disable iff (!nrst)
        lk.rx_reset_req |=> rx_reset ##1 (!rx_reset || $past(lk.rx_reset_req));
    endproperty
    a_rx_reset: assert property (p_rx_reset) else $error("receiver reset pulse wrong");

    property p_err_sets;
        @(posedge clk) disable iff (!nrst)
        rx_error_in |=> lk.rx_error;
    endproperty
    a_err_sets: assert property (p_err_sets) else $error("error flag missed");
endmodule

//--- core/usb_node_config_regs.sv
module usb_node_config_regs #(
    parameter logic [7:0] CHIP_ID = 8'h5a,  // Arbitrary value
    parameter logic [7:0] BLK_REV = 8'h13,  // Arbitrary value
    parameter logic [7:0] BLK_VER = 8'h07   // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        cfg_req,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic             cfg_nack,
    output logic [31:0]      cfg_rdata,
    output logic             header_one_byte,
    output logic [15:0]      node_id,
    output logic [6:0]       sysclk_mhz,
    output logic [10:0]      symbol_gap,
    output logic [10:0]      token_gap,
    input  wire logic        credit_in,
    input  wire logic        credit_issued_in,
    input  wire logic        rx_error_in,
    output logic             credit_request_token,
    output logic             rx_reset
);
    typedef struct packed {
        logic        lock;    // Update lock, sticky
        logic        hdr;     // Header format
        logic [15:0] nid;     // Node identifier
        logic [6:0]  mhz;     // System clock in MHz
        logic [10:0] sym;     // Symbol gap minus one
        logic [10:0] tok;     // Token gap minus one
        logic        ack;     // Answer pulses
        logic        nack;
        logic [31:0] rdata;   // Read data, held until next answer
        logic        crt;     // Credit request strobe
        logic        rxrst;   // Receiver reset strobe
    } regs_t;

    regs_t s_r;  // Registered state
    regs_t s_nxt;  // Next state

    link_ctl_if lk ();  // Link end carrier

    // True for the five numbers that answer
    function automatic logic mapped(input logic [7:0] a);
        return a == usb_cfg_pkg::OFF_ID || a == usb_cfg_pkg::OFF_NODE_CFG ||
               a == usb_cfg_pkg::OFF_NODE_ID || a == usb_cfg_pkg::OFF_SYSCLK ||
               a == usb_cfg_pkg::OFF_LINK;
    endfunction

    // Read word; reserved and write-only bits come back zero
    function automatic logic [31:0] read_word(input logic [7:0] a, input regs_t st,
                                              input logic e, input logic i, input logic h);
        logic [31:0] w;
        w = 32'h0;
        case (a)
            usb_cfg_pkg::OFF_ID: begin
                w[usb_cfg_pkg::ID_CHIP_LO +: 8] = CHIP_ID;
                w[usb_cfg_pkg::ID_REV_LO +: 8]  = BLK_REV;
                w[usb_cfg_pkg::ID_VER_LO +: 8]  = BLK_VER;
            end
            usb_cfg_pkg::OFF_NODE_CFG: begin
                w[usb_cfg_pkg::LOCK_BIT] = st.lock;
                w[usb_cfg_pkg::HDR_BIT]  = st.hdr;
            end
            usb_cfg_pkg::OFF_NODE_ID: w[15:0] = st.nid;
            usb_cfg_pkg::OFF_SYSCLK:  w[6:0]  = st.mhz;
            usb_cfg_pkg::OFF_LINK: begin
                w[usb_cfg_pkg::ERR_BIT]    = e;
                w[usb_cfg_pkg::ISSUED_BIT] = i;
                w[usb_cfg_pkg::HELD_BIT]   = h;
                w[usb_cfg_pkg::SYM_HI:usb_cfg_pkg::SYM_LO] = st.sym;
                w[usb_cfg_pkg::TOK_HI:usb_cfg_pkg::TOK_LO] = st.tok;
            end
            default: w = 32'h0;
        endcase
        return w;
    endfunction

    // One request per cycle; answer in the next cycle
    always_comb begin
        s_nxt       = s_r;
        s_nxt.ack   = 1'b0;
        s_nxt.nack  = 1'b0;
        s_nxt.crt   = 1'b0;
        s_nxt.rxrst = 1'b0;
        if (cfg_req && !cfg_write) begin
            // Unmapped reads return zero with a nack
            s_nxt.rdata = read_word(cfg_addr, s_r, lk.rx_error, lk.credit_issued,
                                    lk.credit_held);
            s_nxt.ack   = mapped(cfg_addr);
            s_nxt.nack  = !mapped(cfg_addr);
        end else if (cfg_req) begin
            s_nxt.rdata = 32'h0;
            s_nxt.ack   = 1'b1;
            case (cfg_addr)
                usb_cfg_pkg::OFF_NODE_CFG: begin
                    if (s_r.lock) begin
                        s_nxt.ack  = 1'b0;
                        s_nxt.nack = 1'b1;
                    end else begin
                        // Writing zero cannot drop the lock, it is only ever set
                        s_nxt.lock = cfg_wdata[usb_cfg_pkg::LOCK_BIT];
                        s_nxt.hdr  = cfg_wdata[usb_cfg_pkg::HDR_BIT];
                    end
                end
                usb_cfg_pkg::OFF_NODE_ID: s_nxt.nid = cfg_wdata[15:0];
                usb_cfg_pkg::OFF_SYSCLK: begin
                    // Upper bits must be clear too, else a large value aliases in range
                    if (cfg_wdata[31:7] == 25'h0 &&
                        cfg_wdata[6:0] >= usb_cfg_pkg::MHZ_MIN &&
                        cfg_wdata[6:0] <= usb_cfg_pkg::MHZ_MAX) begin
                        s_nxt.mhz = cfg_wdata[6:0];
                    end else begin
                        s_nxt.ack  = 1'b0;
                        s_nxt.nack = 1'b1;
                    end
                end
                usb_cfg_pkg::OFF_LINK: begin
                    if (s_r.lock) begin
                        s_nxt.ack  = 1'b0;
                        s_nxt.nack = 1'b1;
                    end else begin
                        s_nxt.sym   = cfg_wdata[usb_cfg_pkg::SYM_HI:usb_cfg_pkg::SYM_LO];
                        s_nxt.tok   = cfg_wdata[usb_cfg_pkg::TOK_HI:usb_cfg_pkg::TOK_LO];
                        s_nxt.crt   = cfg_wdata[usb_cfg_pkg::CRT_BIT];
                        s_nxt.rxrst = cfg_wdata[usb_cfg_pkg::RXRST_BIT];
                    end
                end
                default: begin
                    // Identification and unmapped numbers refuse writes
                    s_nxt.ack  = 1'b0;
                    s_nxt.nack = 1'b1;
                end
            endcase
        end
        // Lock can only be set, never cleared, short of reset
        s_nxt.lock = s_nxt.lock | s_r.lock;
    end

    // State register with documented values after reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r       <= '0;
            s_r.mhz   <= usb_cfg_pkg::MHZ_RST;
            s_r.sym   <= usb_cfg_pkg::GAP_RST;
            s_r.tok   <= usb_cfg_pkg::GAP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lk.crt_req      = s_r.crt;
    assign lk.rx_reset_req = s_r.rxrst;

    // Credit and error flags live beside the link end
    link_credit_ctl u_credit (
        .clk                  (clk),
        .nrst                 (nrst),
        .lk                   (lk),
        .credit_in            (credit_in),
        .credit_issued_in     (credit_issued_in),
        .rx_error_in          (rx_error_in),
        .credit_request_token (credit_request_token),
        .rx_reset             (rx_reset)
    );

    assign cfg_ack         = s_r.ack;
    assign cfg_nack        = s_r.nack;
    assign cfg_rdata       = s_r.rdata;
    assign header_one_byte = s_r.hdr;
    assign node_id         = s_r.nid;
    assign sysclk_mhz      = s_r.mhz;
    assign symbol_gap      = s_r.sym;
    assign token_gap       = s_r.tok;

    property p_lock_sticky;
        @(posedge clk) disable iff (!nrst)
        s_r.lock |=> s_r.lock;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");

    property p_locked_refuse;
        @(posedge clk) disable iff (!nrst)
        s_r.lock && cfg_req && cfg_write &&
        (cfg_addr == usb_cfg_pkg::OFF_LINK || cfg_addr == usb_cfg_pkg::OFF_NODE_CFG)
        |=> cfg_nack && !cfg_ack && $stable(token_gap) && $stable(header_one_byte);
    endproperty
    a_locked_refuse: assert property (p_locked_refuse) else $error("locked write taken");

    property p_hdr_write;
        @(posedge clk) disable iff (!nrst)
        !s_r.lock && cfg_req && cfg_write && cfg_addr == usb_cfg_pkg::OFF_NODE_CFG
        |=> header_one_byte == $past(cfg_wdata[0]) && cfg_ack;
    endproperty
    a_hdr_write: assert property (p_hdr_write) else $error("header mode not stored");

    property p_nid_write;
        @(posedge clk) disable iff (!nrst)
        cfg_req && cfg_write && cfg_addr == usb_cfg_pkg::OFF_NODE_ID
        |=> node_id == $past(cfg_wdata[15:0]);
    endproperty
    a_nid_write: assert property (p_nid_write) else $error("node id not stored");

    property p_mhz_range;
        @(posedge clk) disable iff (!nrst)
        sysclk_mhz >= usb_cfg_pkg::MHZ_MIN && sysclk_mhz <= usb_cfg_pkg::MHZ_MAX;
    endproperty
    a_mhz_range: assert property (p_mhz_range) else $error("clock field out of range");

    property p_mhz_refuse;
        @(posedge clk) disable iff (!nrst)
        cfg_req && cfg_write && cfg_addr == usb_cfg_pkg::OFF_SYSCLK &&
        (cfg_wdata > 32'h64 || cfg_wdata < 32'h5)
        |=> cfg_nack && $stable(sysclk_mhz);
    endproperty
    a_mhz_refuse: assert property (p_mhz_refuse) else $error("bad clock write taken");

    property p_id_read;
        @(posedge clk) disable iff (!nrst)
        cfg_req && !cfg_write && cfg_addr == usb_cfg_pkg::OFF_ID
        |=> cfg_ack && cfg_rdata == {CHIP_ID, 8'h00, BLK_REV, BLK_VER};
    endproperty
    a_id_read: assert property (p_id_read) else $error("identification word wrong");

    property p_gap_write;
        @(posedge clk) disable iff (!nrst)
        !s_r.lock && cfg_req && cfg_write && cfg_addr == usb_cfg_pkg::OFF_LINK
        |=> symbol_gap == $past(cfg_wdata[21:11]) && token_gap == $past(cfg_wdata[10:0]);
    endproperty
    a_gap_write: assert property (p_gap_write) else $error("gap fields not stored");

    property p_credit_bits;
        @(posedge clk) disable iff (!nrst)
        credit_in ##1 (cfg_req && !cfg_write && cfg_addr == usb_cfg_pkg::OFF_LINK
        && !lk.crt_req) |=> cfg_rdata[25];
    endproperty
    a_credit_bits: assert property (p_credit_bits) else $error("credit not reported");
endmodule

//--- sim/link_peer_model.sv
// Remote end of the serial link: answers a credit request token with credit
module link_peer_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic credit_request_token,
    input  wire logic err_cmd,
    input  wire logic [31:0] reply_delay,
    output logic      credit_in,
    output logic      credit_issued_in,
    output logic      rx_error_in
);
    timeunit 1ns;
    timeprecision 1ps;

    int wait_cnt;  // Cycles left before the reply, 0 when idle

    // Reply after a settable delay; 1 is prompt, larger values model a slow far end
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt         <= 0;
            credit_in        <= 1'b0;
            credit_issued_in <= 1'b0;
            rx_error_in      <= 1'b0;
        end else begin
            // Grant and accept credit in one go, as a real far end answers a request
            credit_in        <= (wait_cnt == 1);
            credit_issued_in <= (wait_cnt == 1);
            // Errors are injected only when the bench commands them
            rx_error_in      <= err_cmd;
            if (credit_request_token) begin
                wait_cnt <= reply_delay;
            end else if (wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule

//--- sim/usb_node_config_regs_tb.sv
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end

module usb_node_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // One register access with its expected answer
    typedef struct packed {
        logic        w;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        nack;
        logic [31:0] rd;
    } row_t;

    logic        clk, nrst, cfg_req, cfg_write, err_cmd;  // Bench driven controls
    logic [7:0]  cfg_addr;                                // Register number
    logic [31:0] cfg_wdata, cfg_rdata;                    // Data both ways
    logic        cfg_ack, cfg_nack, header_one_byte;      // Answers and header mode
    logic [15:0] node_id;                                 // Identifier level
    logic [6:0]  sysclk_mhz;                              // Clock field level
    logic [10:0] symbol_gap, token_gap;                   // Spacing fields
    logic        credit_in, credit_issued_in, rx_error_in; // From the far end
    logic        credit_request_token, rx_reset;          // To the far end
    int          reply_delay, n_fail, cmp_count;          // Peer delay and tallies

    // Ordinary accesses; a read row holds the value expected back
    localparam row_t ROWS [21] = '{
        '{1'b1, 8'h51, 32'h19, 1'b0, 32'h0},
        '{1'b0, 8'h00, 32'h0, 1'b0, 32'ha3004c1e},
        '{1'b0, 8'h51, 32'h0, 1'b0, 32'h19},
        '{1'b0, 8'h80, 32'h0, 1'b0, 32'h801},
        '{1'b0, 8'h04, 32'h0, 1'b0, 32'h0},
        '{1'b0, 8'h05, 32'h0, 1'b0, 32'h0},
        '{1'b1, 8'h00, 32'hffffffff, 1'b1, 32'h0},
        '{1'b0, 8'h33, 32'h0, 1'b1, 32'h0},
        '{1'b1, 8'h51, 32'h4, 1'b1, 32'h0},
        '{1'b1, 8'h51, 32'h65, 1'b1, 32'h0},
        '{1'b1, 8'h51, 32'h99, 1'b1, 32'h0},
        '{1'b0, 8'h51, 32'h0, 1'b0, 32'h19},
        '{1'b1, 8'h51, 32'h5, 1'b0, 32'h0},
        '{1'b0, 8'h51, 32'h0, 1'b0, 32'h5},
        '{1'b1, 8'h51, 32'h64, 1'b0, 32'h0},
        '{1'b1, 8'h05, 32'hffffbeef, 1'b0, 32'h0},
        '{1'b0, 8'h05, 32'h0, 1'b0, 32'hbeef},
        '{1'b1, 8'h04, 32'h7fffffff, 1'b0, 32'h0},
        '{1'b0, 8'h04, 32'h0, 1'b0, 32'h1},
        '{1'b1, 8'h80, 32'hf07fffff, 1'b0, 32'h0},
        '{1'b0, 8'h80, 32'h0, 1'b0, 32'h3fffff}
    };

    usb_node_config_regs #(
        .CHIP_ID (8'ha3),  // Arbitrary value
        .BLK_REV (8'h4c),  // Arbitrary value
        .BLK_VER (8'h1e)   // Arbitrary value
    ) u_dut (
        .clk(clk), .nrst(nrst), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_nack(cfg_nack), .cfg_rdata(cfg_rdata), .header_one_byte(header_one_byte),
        .node_id(node_id), .sysclk_mhz(sysclk_mhz), .symbol_gap(symbol_gap),
        .token_gap(token_gap), .credit_in(credit_in), .credit_issued_in(credit_issued_in),
        .rx_error_in(rx_error_in), .credit_request_token(credit_request_token),
        .rx_reset(rx_reset)
    );

    link_peer_model u_peer (
        .clk(clk), .nrst(nrst), .credit_request_token(credit_request_token),
        .err_cmd(err_cmd), .reply_delay(reply_delay), .credit_in(credit_in),
        .credit_issued_in(credit_issued_in), .rx_error_in(rx_error_in)
    );

    // Free running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Verdict and end of run, reached from the main flow and from a spent wait
    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One request held over its taking edge; the answer is sampled 1 ns after that edge
    task automatic access(input row_t r);
        @(posedge clk);
        #1 cfg_req = 1'b1;
        cfg_write = r.w;
        cfg_addr  = r.addr;
        cfg_wdata = r.wdata;
        @(posedge clk);
        #1 cfg_req = 1'b0;
        `CHK(cfg_ack, ~r.nack);
        `CHK(cfg_nack, r.nack);
        if (!r.w && !r.nack) `CHK(cfg_rdata, r.rd);
    endtask

    // Bounded wait for the far end to hand credit back
    task automatic wait_credit();
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            #1;
            if (credit_in === 1'b1) return;
        end
        n_fail++;
        stop_test();
    endtask

    // Main sequence
    initial begin
        {cfg_req, cfg_write, err_cmd, nrst} = 4'h0;
        {cfg_addr, cfg_wdata} = 40'h0;
        {n_fail, cmp_count} = 0;
        reply_delay = 20;
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        foreach (ROWS[i]) access(ROWS[i]);
        `CHK(header_one_byte, 1'b1);
        `CHK(node_id, 16'hbeef);
        `CHK(sysclk_mhz, 7'h64);
        `CHK(symbol_gap, 11'h7ff);
        `CHK(token_gap, 11'h7ff);
        // Credit request with a slow far end: held credit is gone until the reply
        access('{1'b1, 8'h80, 32'h01001002, 1'b0, 32'h0});
        @(posedge clk);
        #1 `CHK(credit_request_token, 1'b1);
        access('{1'b0, 8'h80, 32'h0, 1'b0, 32'h00001002});
        wait_credit();
        access('{1'b0, 8'h80, 32'h0, 1'b0, 32'h06001002});
        // Injected error, then a receiver restart clears error and issued flags
        err_cmd = 1'b1;
        @(posedge clk);
        #1 err_cmd = 1'b0;
        access('{1'b0, 8'h80, 32'h0, 1'b0, 32'h0e001002});
        access('{1'b1, 8'h80, 32'h00801002, 1'b0, 32'h0});
        @(posedge clk);
        #1 `CHK(rx_reset, 1'b1);
        access('{1'b0, 8'h80, 32'h0, 1'b0, 32'h02001002});
        // Prompt far end this time
        reply_delay = 1;
        access('{1'b1, 8'h80, 32'h01001002, 1'b0, 32'h0});
        wait_credit();
        access('{1'b0, 8'h80, 32'h0, 1'b0, 32'h06001002});
        // Lock: node config and link writes refused, identifier still open
        access('{1'b1, 8'h04, 32'h80000000, 1'b0, 32'h0});
        `CHK(header_one_byte, 1'b0);
        access('{1'b1, 8'h04, 32'h1, 1'b1, 32'h0});
        access('{1'b1, 8'h80, 32'h0, 1'b1, 32'h0});
        `CHK(token_gap, 11'h002);
        access('{1'b1, 8'h05, 32'h1234, 1'b0, 32'h0});
        access('{1'b0, 8'h04, 32'h0, 1'b0, 32'h80000000});
        // Reset in mid-run is the only way out of the lock
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        `CHK(sysclk_mhz, 7'h19);
        `CHK(node_id, 16'h0000);
        `CHK(symbol_gap, 11'h001);
        `CHK(token_gap, 11'h001);
        access('{1'b0, 8'h04, 32'h0, 1'b0, 32'h0});
        access('{1'b1, 8'h04, 32'h1, 1'b0, 32'h0});
        stop_test();
    end
endmodule
